/* File: hdl/sms_consts.svh */
// Purpose: Constants for the stimulus memory sequencer (offsets, fields, resets, counts)
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Included by the package users; definitions only
//
// Summary of operation
// R1 - End address is last address per pass
// R2 - At end address load return-to address
// R3 - Return-to address resets to zero
// R4 - Supply variant forces return-to to zero
// R5 - Software sets end = return + steps - 1
// R6 - Single write stores, loads counter, increments
// R7 - Fill copies item 0..9 from offset
// R8 - Fill shifts codes, negative means left
// R9 - Each loop outputs return..end words
// R10 - Repeat stimulus exactly measurement-loop-count times
// R11 - Software sets capturing loop count to one
// R12 - Capture stops when capture memory full
// R13 - Settle loops run first, without capture
// R14 - Card mode 0 configure, 1 measure
// R15 - Configuration mode allows backplane memory access
// R16 - Measurement mode detaches buses, runs locally
// R17 - Software enables supply channels before measuring
// R18 - Reference mode 0 static, 1 controlled default
// R19 - Static reference ignores set-voltage commands
// R20 - Rate 4 needs divider 1, 2 needs <=2
// R21 - After last loop, counter and output stop
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

`define SMS_AW             10
`define SMS_DW             32
`define SMS_ITEMS          10

`define SMS_OFF_CTRL       12'h000
`define SMS_OFF_STATUS     12'h004
`define SMS_OFF_ADDR       12'h008
`define SMS_OFF_END        12'h00c
`define SMS_OFF_RET        12'h010
`define SMS_OFF_WADDR      12'h014
`define SMS_OFF_WDATA      12'h018
`define SMS_OFF_FILL       12'h01c
`define SMS_OFF_LOOPS      12'h020
`define SMS_OFF_MODES      12'h024
`define SMS_OFF_VOLT       12'h028
`define SMS_OFF_CAPCNT     12'h02c
`define SMS_OFF_ITEM       12'h030
`define SMS_OFF_OUT        12'h034

`define SMS_CTRL_START     0
`define SMS_CTRL_MEAS      1
`define SMS_CTRL_SUPPLY    2
`define SMS_MODES_REF      0
`define SMS_MODES_RATE_LO  4
`define SMS_MODES_DIV_LO   8

`define SMS_RST_RET        10'h000
`define SMS_RST_MODES      32'h0000_0111
`define SMS_FILL_LEN_W     10
`define SMS_CAP_SIZE       11'h400
`endif

/* File: hdl/sms_pkg.sv */
// Purpose: Types for the stimulus memory sequencer
// Assumes: Constants come from sms_consts.svh
// Notes:   Loop machine states only
package sms_pkg;
    typedef enum logic [2:0] {
        SMS_IDLE, SMS_FILL, SMS_SETTLE, SMS_MEASURE, SMS_DONE
    } sms_state_t;
endpackage

/* File: hdl/sms_mem.sv */
// Purpose: Stimulus memory, one write port, one registered read port
// Assumes: Single clock, depth 2**SMS_AW
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ns
`include "sms_consts.svh"
module sms_mem (
    // Clock
    input  wire logic                 pclk,
    // Write port
    input  wire logic                 we,
    input  wire logic [`SMS_AW-1:0]   waddr,
    input  wire logic [`SMS_DW-1:0]   wdata,
    // Read port
    input  wire logic [`SMS_AW-1:0]   raddr,
    output logic      [`SMS_DW-1:0]   rdata
);
    logic [`SMS_DW-1:0] mem [0:(1<<`SMS_AW)-1];

    // No reset on the array, so it maps to block RAM
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* File: hdl/sms_top.sv */
// Purpose: Stimulus address sequencing, memory fill, loops, capture and mode control
// Assumes: APB slave on pclk; capture samples arrive on cap_valid
// Notes:   Stored signal items are modelled as a small per-item value table
`timescale 1ns/1ns
`include "sms_consts.svh"
module sms_top
    import sms_pkg::*;
(
    // APB
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Stimulus to the device under test
    output logic      [31:0]        stim_data,
    output logic                    stim_valid,
    // Capture from the converter
    input  wire logic               cap_valid,
    output logic                    cap_store,
    // Backplane attach, reference output and busy status
    output logic                    backplane_attach,
    output logic      [31:0]        ref_level,
    output logic                    seq_busy
);
    sms_state_t        state_q, state_d;
    logic [`SMS_AW-1:0] addr_q, end_q, ret_q, fill_a_q, fill_n_q;
    logic [31:0]       loops_q, modes_q, volt_q, ref_q, fill_q;
    logic [31:0]       item_q [0:`SMS_ITEMS-1];
    logic [15:0]       loop_cnt_q;
    logic [10:0]       cap_cnt_q;
    logic              meas_q, supply_q, run_q, out_v_q;
    logic [31:0]       stim_q;

    // APB decode: zero-wait slave, every access completes in its first access cycle
    wire        acc      = psel & penable;
    wire        wr       = acc & pwrite;
    wire        hit_ctrl = paddr == `SMS_OFF_CTRL;
    wire        hit_end  = paddr == `SMS_OFF_END;
    wire        hit_ret  = paddr == `SMS_OFF_RET;
    wire        hit_addr = paddr == `SMS_OFF_ADDR;
    wire        hit_wa   = paddr == `SMS_OFF_WADDR;
    wire        hit_wd   = paddr == `SMS_OFF_WDATA;
    wire        hit_fill = paddr == `SMS_OFF_FILL;
    wire        hit_loop = paddr == `SMS_OFF_LOOPS;
    wire        hit_mode = paddr == `SMS_OFF_MODES;
    wire        hit_volt = paddr == `SMS_OFF_VOLT;
    wire        hit_cap  = paddr == `SMS_OFF_CAPCNT;
    wire        hit_item = paddr[11:6] == 6'h01 && paddr[1:0] == 2'h0
                           && paddr[5:2] < 4'(`SMS_ITEMS);
    wire        hit_stat = paddr == `SMS_OFF_STATUS;
    wire        hit_any  = hit_ctrl | hit_end | hit_ret | hit_addr | hit_wa | hit_wd
                           | hit_fill | hit_loop | hit_mode | hit_volt | hit_cap
                           | hit_item | hit_stat;
    wire        idle     = state_q == SMS_IDLE || state_q == SMS_DONE;
    // Memory writes only through the backplane in configuration mode
    wire        cfg_ok   = ~meas_q;                                      // [R15]

    // Rate check: 4x only with divider 1, 2x only with divider up to 2
    wire [3:0]  rate_w   = pwdata[`SMS_MODES_RATE_LO +: 4];
    wire [7:0]  div_w    = pwdata[`SMS_MODES_DIV_LO +: 8];
    wire        rate_ok  = (rate_w == 4'h1) || (rate_w == 4'h2 && div_w <= 8'h02)
                           || (rate_w == 4'h4 && div_w == 8'h01);       // [R20]
    wire        mode_bad = hit_mode && !rate_ok;

    assign pready  = 1'b1;
    assign pslverr = acc & (~hit_any | (wr & mode_bad));

    // Single-word write from the backplane
    wire        sw_we    = wr & hit_wd & cfg_ok & idle;                 // [R6]
    // Fill: signed shift amount, zero-filled shift, negative means shift left
    wire [3:0]  fill_it  = pwdata[3:0];
    wire        fill_go  = wr & hit_fill & cfg_ok & idle & (fill_it < 4'(`SMS_ITEMS)); // [R7]
    wire signed [7:0] shamt = fill_q[15:8];
    wire [31:0] item_v   = item_q[fill_q[3:0]];
    wire [31:0] shifted  = shamt[7] ? (item_v << (-shamt))
                                    : (item_v >> shamt);                // [R8]
    wire        fill_we  = state_q == SMS_FILL;

    // Memory ports
    wire              mem_we    = sw_we | fill_we;
    wire [`SMS_AW-1:0] mem_waddr = fill_we ? fill_a_q : addr_q;
    wire [31:0]       mem_wdata = fill_we ? shifted : pwdata;
    wire [31:0]       mem_rdata;

    sms_mem u_mem (
        .pclk  (pclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (addr_q),
        .rdata (mem_rdata)
    );

    // Sequencing
    wire        at_end   = addr_q == end_q;                             // [R1]
    wire        in_loops = state_q == SMS_SETTLE || state_q == SMS_MEASURE;
    wire        last_set = loop_cnt_q == 16'h0001 || loop_cnt_q == 16'h0000;
    wire        last_ml  = loop_cnt_q == 16'h0001 || loop_cnt_q == 16'h0000;
    wire        cap_full = cap_cnt_q == `SMS_CAP_SIZE;
    wire        start    = wr & hit_ctrl & pwdata[`SMS_CTRL_START] & idle & meas_q;

    // Next state of the loop machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SMS_IDLE, SMS_DONE: begin
                if (fill_go) begin
                    state_d = SMS_FILL;
                end else if (start) begin
                    state_d = (loops_q[15:0] != 16'h0) ? SMS_SETTLE         // [R13]
                            : (loops_q[31:16] != 16'h0) ? SMS_MEASURE : SMS_DONE;
                end
            end
            SMS_FILL: begin
                if (fill_n_q == '0) begin
                    state_d = SMS_IDLE;
                end
            end
            SMS_SETTLE: begin
                if (at_end && last_set) begin
                    state_d = (loops_q[31:16] != 16'h0) ? SMS_MEASURE : SMS_DONE;
                end
            end
            SMS_MEASURE: begin
                if (at_end && last_ml) begin
                    state_d = SMS_DONE;                                 // [R10] [R21]
                end
            end
        endcase
    end

    // Loop state, counters and address counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= SMS_IDLE;
            addr_q     <= '0;
            fill_a_q   <= '0;
            fill_n_q   <= '0;
            loop_cnt_q <= '0;
            cap_cnt_q  <= '0;
        end else begin
            state_q <= state_d;
            if (fill_go) begin
                fill_a_q <= pwdata[16 +: `SMS_AW];
                fill_n_q <= ~pwdata[16 +: `SMS_AW];
            end else if (fill_we) begin
                fill_a_q <= fill_a_q + 1'b1;
                fill_n_q <= fill_n_q - 1'b1;
            end
            if (start) begin
                addr_q     <= ret_q;
                loop_cnt_q <= (loops_q[15:0] != 16'h0) ? loops_q[15:0] : loops_q[31:16];
                cap_cnt_q  <= '0;
            end else if (in_loops) begin
                if (at_end) begin
                    addr_q <= ret_q;                                    // [R2] [R9]
                    if (state_d == SMS_MEASURE && state_q == SMS_SETTLE) begin
                        loop_cnt_q <= loops_q[31:16];
                    end else begin
                        loop_cnt_q <= loop_cnt_q - 1'b1;
                    end
                end else begin
                    addr_q <= addr_q + 1'b1;
                end
            end else if (sw_we) begin
                addr_q <= addr_q + 1'b1;                                // [R6]
            end else if (wr & hit_wa & idle) begin
                addr_q <= pwdata[`SMS_AW-1:0];                          // [R6]
            end else if (wr & hit_addr & idle) begin
                addr_q <= pwdata[`SMS_AW-1:0];
            end
            // Capture only in measure loops, and never past the memory size
            if (cap_store) begin
                cap_cnt_q <= cap_cnt_q + 1'b1;                          // [R12]
            end
        end
    end

    assign cap_store = state_q == SMS_MEASURE && cap_valid && !cap_full; // [R12] [R13]

    // Registered stimulus output; frozen once the sequence is done.
    // Valid follows the loop state by two cycles, so the end word of the
    // final pass still leaves after the machine has reached done.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stim_q  <= '0;
            out_v_q <= 1'b0;
            run_q   <= 1'b0;
        end else begin
            run_q   <= in_loops;
            out_v_q <= run_q;
            if (run_q) begin
                stim_q <= mem_rdata;                                    // [R9] [R21]
            end
        end
    end
    assign stim_data  = stim_q;
    assign stim_valid = out_v_q;

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_q    <= '0;
            ret_q    <= `SMS_RST_RET;                                   // [R3]
            loops_q  <= '0;
            modes_q  <= `SMS_RST_MODES;                                 // [R18]
            volt_q   <= '0;
            ref_q    <= '0;
            fill_q   <= '0;
            meas_q   <= 1'b0;
            supply_q <= 1'b0;
        end else begin
            if (wr & hit_ctrl) begin
                meas_q   <= pwdata[`SMS_CTRL_MEAS];                      // [R14]
                supply_q <= pwdata[`SMS_CTRL_SUPPLY];
            end
            if (wr & hit_ctrl & pwdata[`SMS_CTRL_SUPPLY]) begin
                ret_q <= '0;                                            // [R4]
            end else if (wr & hit_ret & idle & ~supply_q) begin
                ret_q <= pwdata[`SMS_AW-1:0];                           // [R4]
            end
            if (wr & hit_end & idle) begin
                end_q <= pwdata[`SMS_AW-1:0];
            end
            if (wr & hit_loop & idle) begin
                loops_q <= pwdata;
            end
            if (wr & hit_mode & rate_ok) begin
                modes_q <= pwdata;                                      // [R20]
            end
            if (fill_go) begin
                fill_q <= pwdata;
            end
            if (wr & hit_volt) begin
                volt_q <= pwdata;
            end
            // Static mode holds the output; a stored level is applied on switch to controlled
            if (modes_q[`SMS_MODES_REF]) begin
                ref_q <= volt_q;                                        // [R19]
            end
        end
    end

    // Signal item table written over the bus
    genvar gi;
    generate
        for (gi = 0; gi < `SMS_ITEMS; gi = gi + 1) begin : g_item
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    item_q[gi] <= '0;
                end else if (wr & hit_item & (paddr[5:2] == 4'(gi))) begin
                    item_q[gi] <= pwdata;
                end
            end
        end
    endgenerate

    assign ref_level        = ref_q;
    assign backplane_attach = ~meas_q;                                  // [R16]
    assign seq_busy         = ~idle;

    // Read mux
    wire [31:0] status_w = {27'h0, state_q == SMS_DONE, cap_full, state_q};
    always_comb begin
        prdata = 32'h0;
        if (hit_ctrl)      prdata = {29'h0, supply_q, meas_q, 1'b0};
        else if (hit_stat) prdata = status_w;
        else if (hit_addr) prdata = {22'h0, addr_q};
        else if (hit_end)  prdata = {22'h0, end_q};
        else if (hit_ret)  prdata = {22'h0, ret_q};
        else if (hit_fill) prdata = fill_q;
        else if (hit_loop) prdata = loops_q;
        else if (hit_mode) prdata = modes_q;
        else if (hit_volt) prdata = volt_q;
        else if (hit_cap)  prdata = {21'h0, cap_cnt_q};
        else if (hit_item) prdata = item_q[paddr[5:2]];
    end
endmodule

/* File: verif/sms_checker_sva.sv */
// Purpose: Port checks for the stimulus memory sequencer
// Assumes: One clock, presetn asynchronous active low
// Notes:   Helpers track reference mode and captures per run
`timescale 1ns/1ns
module sms_checker (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Stream and capture
    input wire logic [31:0] stim_data,
    input wire logic        stim_valid,
    input wire logic        cap_valid,
    input wire logic        cap_store,
    // Mode and status
    input wire logic        backplane_attach,
    input wire logic [31:0] ref_level,
    input wire logic        seq_busy
);
    // Accepted accesses; the slave never inserts wait states
    wire logic acc  = psel && penable;
    wire logic mw   = acc && pwrite && paddr == 12'h024 && !pslverr;
    wire logic strt = acc && pwrite && paddr == 12'h000 && pwdata[0];
    logic        ref_ctl_q;
    logic [10:0] cap_cnt_q;
    // Captures counted per run, so a stale total cannot mask a late store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ctl_q <= 1'b1;
            cap_cnt_q <= 11'h000;
        end else begin
            if (mw) ref_ctl_q <= pwdata[0];
            if (strt) cap_cnt_q <= 11'h000;
            else if (cap_store) cap_cnt_q <= cap_cnt_q + 11'h001;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_attach; acc && pwrite && paddr == 12'h000 |=> backplane_attach == !$past(pwdata[1]);
    endproperty
    a_attach: assert property (p_attach) else $error("attach wrong");
    property p_rate4; mw && pwdata[7:4] == 4'h4 |-> pwdata[15:8] == 8'h01; endproperty
    a_rate4: assert property (p_rate4) else $error("rate four taken");
    property p_rate2; mw && pwdata[7:4] == 4'h2 |-> pwdata[15:8] <= 8'h02; endproperty
    a_rate2: assert property (p_rate2) else $error("rate two taken");
    property p_cap; cap_store |-> cap_valid && !backplane_attach; endproperty
    a_cap: assert property (p_cap) else $error("store without sample");
    property p_full; cap_cnt_q == 11'h400 |-> !cap_store; endproperty
    a_full: assert property (p_full) else $error("store past full");
    property p_static; !ref_ctl_q && !mw |=> $stable(ref_level); endproperty
    a_static: assert property (p_static) else $error("static level moved");
    property p_freeze; $fell(seq_busy) |-> ##4 $stable(stim_data) [*3]; endproperty
    a_freeze: assert property (p_freeze) else $error("output moved after run");
    cover property (strt);
    cover property (cap_store);
    cover property (acc && pslverr);
endmodule
bind sms_top sms_checker i_sms_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stim_data(stim_data), .stim_valid(stim_valid),
    .cap_valid(cap_valid), .cap_store(cap_store), .backplane_attach(backplane_attach),
    .ref_level(ref_level), .seq_busy(seq_busy));

/* File: verif/sms_conv_model.sv */
// Purpose: Converter model that offers capture samples
// Assumes: One sample pulse per clock, or every other when slow
// Notes:   Samples only while enabled
`timescale 1ns/1ns
module sms_conv_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control from the bench
    input  wire logic en,
    input  wire logic slow,
    // Sample strobe
    output logic      cap_valid
);
    logic ph_q;
    // Slow mode halves the rate to exercise gaps between samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ph_q <= 1'b0;
        else ph_q <= ~ph_q;
    end
    assign cap_valid = en && (!slow || ph_q);
endmodule

/* File: verif/testbench.sv */
// Purpose: Register and streaming tests of the sequencer
// Assumes: Zero-wait APB slave, 100 MHz clock
// Notes:   Expected words follow from the programmed bounds
`timescale 1ns/1ns
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        cap_en = 1'b0, cap_slow = 1'b1, cap_valid, err_q;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, stim_data, ref_level, rd_q;
    logic        pready, pslverr, stim_valid, cap_store, backplane_attach, seq_busy;
    logic [31:0] seen [0:15];
    logic [31:0] modes [0:5] = '{32'h110, 32'h120, 32'h220, 32'h320, 32'h240, 32'h140};
    logic [5:0]  bad = 6'b011000;
    logic [31:0] exp4 [0:3] = '{32'h3cc, 32'ha3, 32'ha4, 32'h3cc};
    int          n_stim = 0, error_cnt = 0, num_checks = 0;

    sms_top i_sms_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stim_data(stim_data), .stim_valid(stim_valid),
        .cap_valid(cap_valid), .cap_store(cap_store), .backplane_attach(backplane_attach),
        .ref_level(ref_level), .seq_busy(seq_busy));
    sms_conv_model i_sms_conv_model (.pclk(pclk), .presetn(presetn), .en(cap_en),
        .slow(cap_slow), .cap_valid(cap_valid));

    // Clock, 10 ns period
    always #5 pclk = ~pclk;
    // Record streamed words
    always @(posedge pclk) begin
        if (stim_valid === 1'b1) begin
            if (n_stim < 16) seen[n_stim] = stim_data;
            n_stim++;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Poll status; the watchdog bounds the wait
    task automatic poll(input logic [31:0] mask, input logic [31:0] val);
        do apb(1'b0, 12'h004, 32'h0); while ((rd_q & mask) !== val);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog, well beyond the two runs
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        test_done;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        check(rd_q, 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        check(rd_q, 32'h111);
        // Single-word write, back to back
        apb(1'b1, 12'h014, 32'h10);
        apb(1'b1, 12'h018, 32'haa55);
        apb(1'b0, 12'h008, 32'h0);
        check(rd_q, 32'h11);
        apb(1'b0, 12'h0f0, 32'h0);
        check({31'h0, err_q}, 32'h1);
        // Rate and divider pairs; the last leaves the reference static
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h024, modes[i]);
            check({31'h0, err_q}, {31'h0, bad[i]});
        end
        apb(1'b0, 12'h024, 32'h0);
        check(rd_q, 32'h140);
        apb(1'b1, 12'h028, 32'h1234);
        check(ref_level, 32'h0);
        apb(1'b1, 12'h024, 32'h141);
        // The level is copied one edge after the mode lands; look once it has settled
        @(posedge pclk);
        check(ref_level, 32'h1234);
        // Supply variant keeps return-to at zero
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b1, 12'h010, 32'h7);
        apb(1'b0, 12'h010, 32'h0);
        check(rd_q, 32'h0);
        check({31'h0, backplane_attach}, 32'h1);
        // Supply variant is left again without ever entering measurement mode
        apb(1'b1, 12'h000, 32'h0);
        // Fill item 3 shifted left by two, then patch two words
        apb(1'b1, 12'h04c, 32'hf3);
        apb(1'b1, 12'h01c, 32'h0000_fe03);
        poll(32'h7, 32'h0);
        apb(1'b1, 12'h014, 32'h3);
        apb(1'b1, 12'h018, 32'ha3);
        apb(1'b1, 12'h018, 32'ha4);
        // Four steps from 2: end is 5; one settle and two measure loops
        apb(1'b1, 12'h010, 32'h2);
        apb(1'b1, 12'h00c, 32'h5);
        apb(1'b1, 12'h020, 32'h0002_0001);
        n_stim = 0;
        cap_en <= 1'b1;
        // Start is only taken once measurement mode already stands
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b1, 12'h000, 32'h3);
        check({31'h0, backplane_attach}, 32'h0);
        poll(32'h10, 32'h10);
        repeat (4) @(posedge pclk);
        check(n_stim, 32'd12);
        for (int i = 0; i < 12; i++) begin
            check(seen[i], exp4[i % 4]);
        end
        // A capturing card normally runs one loop two full passes
        // at full rate here push capture past the memory size
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h00c, 32'h3ff);
        apb(1'b1, 12'h020, 32'h0002_0000);
        cap_slow <= 1'b0;
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b1, 12'h000, 32'h3);
        poll(32'h10, 32'h10);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h02c, 32'h0);
        check(rd_q, 32'h400);
        apb(1'b0, 12'h004, 32'h0);
        check({31'h0, rd_q[3]}, 32'h1);
        test_done;
    end
endmodule
